// >>> common/lcr_consts.vh
// Constants for the LED command port and RGB dimmer
`ifndef LCR_CONSTS_VH
`define LCR_CONSTS_VH

`define LCR_ADDR_W 8
`define LCR_OFS_CMD 8'h00
`define LCR_OFS_SHIFT 8'h04
`define LCR_OFS_STATUS 8'h08
`define LCR_OFS_CTRL 8'h0c

`define LCR_CMD_W 16
`define LCR_CMD_RESET 16'h0000
`define LCR_MAIN_HI 15
`define LCR_MAIN_LO 14
`define LCR_SUB_HI 13
`define LCR_SUB_LO 12
`define LCR_BLUE_HI 11
`define LCR_BLUE_LO 8
`define LCR_GREEN_HI 7
`define LCR_GREEN_LO 4
`define LCR_RED_HI 3
`define LCR_RED_LO 0

`define LCR_CTRL_W 2
`define LCR_CTRL_RESET 2'h1
`define LCR_CTRL_RGB_EN 0
`define LCR_CTRL_FORCE_BOOST 1

`define LCR_LVL_OFF 2'h0
`define LCR_LVL_QUARTER 2'h1
`define LCR_LVL_HALF 2'h2
`define LCR_LVL_FULL 2'h3
`define LCR_PCT_0 7'h00
`define LCR_PCT_25 7'h19
`define LCR_PCT_50 7'h32
`define LCR_PCT_100 7'h64

`define LCR_PWM_PERIOD 240
`define LCR_PWM_CNT_W 8
`define LCR_PWM_LAST 8'hef
`define LCR_DUTY_W 4
`define LCR_DUTY_STEP_SHIFT 4

`define LCR_HTRANS_NONSEQ 2'h2
`define LCR_HTRANS_SEQ 2'h3
`define LCR_WHITE_SINKS 6

`endif

// >>> hw/lcr_dimmer.v
// LED command port, white dimming, pump mode select and RGB PWM
// Behaviour
// - Dropout on any lit one of the six white sinks (level on, not near the pump) moves the pump from direct mode to 2:3 boost.
// - An open or grounded white sink reports dropout and so forces boost.
// - A white sink near the pump output has its LED current off, test current on while its level is on, no dropout.
// - Colour sinks never take part in pump mode selection.
// - Each colour channel has its own duty from 0/15 to 15/15 in steps of 1/15.
// - Each 4-bit colour code, MSB first, is an unsigned n giving n fifteenths.
// - The shift register is copied to the command register on the strobe falling edge.
// - New command settings drive the outputs at once, with no further handshake.
// - Data are sampled on each rising serial clock, MSB first, with no minimum rate.
// - Bits 15-14 main level, 13-12 sub level, 11-8 blue, 7-4 green, 3-0 red.
// - White level codes 00, 01, 10, 11 select 0, 25, 50 and 100 percent.
// - The colour PWM period spans 240 pump oscillator cycles.
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`include "lcr_consts.vh"

module lcr_dimmer #(
    parameter CMD_W = `LCR_CMD_W,
    parameter SINKS = `LCR_WHITE_SINKS
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire serial_data,
    input wire serial_clock,
    input wire load_strobe_n,
    input wire pump_osc,
    input wire [3:0] primary_led_sinks,
    input wire secondary_led_sink_a,
    input wire secondary_led_sink_b,
    input wire [5:0] sink_near_pump,
    output reg [6:0] main_level_pct_r,
    output reg [6:0] sub_level_pct_r,
    output reg [5:0] sink_current_en_r,
    output reg [5:0] sink_test_current_r,
    output reg pump_enable_r,
    output reg boost_mode_r,
    output reg red_pwm_r,
    output reg green_pwm_r,
    output reg blue_pwm_r
);
    // Level code to percent of full scale, used for main and sub
    function [6:0] level_pct;
        input [1:0] code;
        begin
            case (code)
                `LCR_LVL_QUARTER: level_pct = `LCR_PCT_25;
                `LCR_LVL_HALF: level_pct = `LCR_PCT_50;
                `LCR_LVL_FULL: level_pct = `LCR_PCT_100;
                default: level_pct = `LCR_PCT_0;
            endcase
        end
    endfunction

    // Exact match of the low address byte against a register offset
    function is_reg;
        input [`LCR_ADDR_W-1:0] addr;
        input [`LCR_ADDR_W-1:0] ofs;
        begin
            is_reg = (addr == ofs);
        end
    endfunction

    // Pin synchronisers; a third stage only for edge detection
    reg [2:0] sclk_s;
    reg [1:0] sdat_s;
    reg [2:0] ld_s;
    reg [2:0] osc_s;
    reg [SINKS-1:0] drop_s1;
    reg [SINKS-1:0] drop_s2;
    reg [SINKS-1:0] near_s1;
    reg [SINKS-1:0] near_s2;

    reg [CMD_W-1:0] shift_r;
    reg [CMD_W-1:0] cmd_r;
    reg [4:0] bit_cnt_r;
    reg [`LCR_PWM_CNT_W-1:0] phase_r;
    reg [`LCR_CTRL_W-1:0] ctrl_r;

    reg dp_write_r;
    reg [`LCR_ADDR_W-1:0] dp_addr_r;

    // Count saturates at a full command, so it never wraps
    localparam [4:0] BITS_FULL = CMD_W;

    wire sclk_rise;
    wire ld_fall;
    wire osc_rise;
    wire [SINKS-1:0] sink_drop_raw;
    wire [SINKS-1:0] sink_drop_eff;
    wire [SINKS-1:0] sink_on;
    wire main_on;
    wire sub_on;
    wire rgb_on;
    wire addr_phase;
    wire red_w;
    wire green_w;
    wire blue_w;
    reg [31:0] rd_mux;

    assign sink_drop_raw = {secondary_led_sink_b, secondary_led_sink_a, primary_led_sinks};

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sclk_s <= 3'h7;
            sdat_s <= 2'h0;
            ld_s <= 3'h7;
            osc_s <= 3'h0;
            drop_s1 <= {SINKS{1'b0}};
            drop_s2 <= {SINKS{1'b0}};
            near_s1 <= {SINKS{1'b0}};
            near_s2 <= {SINKS{1'b0}};
        end
        else
        begin
            sclk_s <= {sclk_s[1:0], serial_clock};
            sdat_s <= {sdat_s[0], serial_data};
            ld_s <= {ld_s[1:0], load_strobe_n};
            osc_s <= {osc_s[1:0], pump_osc};
            drop_s1 <= sink_drop_raw;
            drop_s2 <= drop_s1;
            near_s1 <= sink_near_pump;
            near_s2 <= near_s1;
        end
    end

    // Clock idles high, so only rising edges after the first fall shift data
    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign ld_fall = ~ld_s[1] & ld_s[2];
    assign osc_rise = osc_s[1] & ~osc_s[2];

    // Serial shift and command latch
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            shift_r <= `LCR_CMD_RESET;
            cmd_r <= `LCR_CMD_RESET;
            bit_cnt_r <= 5'h00;
        end
        else
        begin
            if (sclk_rise)
            begin
                shift_r <= {shift_r[CMD_W-2:0], sdat_s[1]};
                if (bit_cnt_r != BITS_FULL)
                    bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            if (ld_fall)
            begin
                cmd_r <= shift_r;
                bit_cnt_r <= 5'h00;
            end
        end
    end

    assign main_on = (cmd_r[`LCR_MAIN_HI:`LCR_MAIN_LO] != `LCR_LVL_OFF);
    assign sub_on = (cmd_r[`LCR_SUB_HI:`LCR_SUB_LO] != `LCR_LVL_OFF);
    assign rgb_on = (cmd_r[`LCR_BLUE_HI:`LCR_RED_LO] != 12'h000);
    assign sink_on = {sub_on, sub_on, main_on, main_on, main_on, main_on};

    assign sink_drop_eff = drop_s2 & ~near_s2 & sink_on;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            phase_r <= {`LCR_PWM_CNT_W{1'b0}};
        else if (osc_rise)
            phase_r <= (phase_r == `LCR_PWM_LAST) ? {`LCR_PWM_CNT_W{1'b0}} :
                phase_r + 8'h01;
    end

    lcr_pwm_chan u_red (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(ctrl_r[`LCR_CTRL_RGB_EN]),
        .phase(phase_r),
        .duty(cmd_r[`LCR_RED_HI:`LCR_RED_LO]),
        .pwm_out_r(red_w)
    );

    lcr_pwm_chan u_green (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(ctrl_r[`LCR_CTRL_RGB_EN]),
        .phase(phase_r),
        .duty(cmd_r[`LCR_GREEN_HI:`LCR_GREEN_LO]),
        .pwm_out_r(green_w)
    );

    lcr_pwm_chan u_blue (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(ctrl_r[`LCR_CTRL_RGB_EN]),
        .phase(phase_r),
        .duty(cmd_r[`LCR_BLUE_HI:`LCR_BLUE_LO]),
        .pwm_out_r(blue_w)
    );

    // Output stage; one cycle after the command latch, two for the colour PWM outputs
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            main_level_pct_r <= `LCR_PCT_0;
            sub_level_pct_r <= `LCR_PCT_0;
            sink_current_en_r <= {SINKS{1'b0}};
            sink_test_current_r <= {SINKS{1'b0}};
            pump_enable_r <= 1'b0;
            boost_mode_r <= 1'b0;
            red_pwm_r <= 1'b0;
            green_pwm_r <= 1'b0;
            blue_pwm_r <= 1'b0;
        end
        else
        begin
            main_level_pct_r <= level_pct(cmd_r[`LCR_MAIN_HI:`LCR_MAIN_LO]);
            sub_level_pct_r <= level_pct(cmd_r[`LCR_SUB_HI:`LCR_SUB_LO]);
            sink_current_en_r <= sink_on & ~near_s2;
            sink_test_current_r <= sink_on & near_s2;
            pump_enable_r <= main_on | sub_on | rgb_on;
            boost_mode_r <= (main_on | sub_on | rgb_on) &
                ((|sink_drop_eff) | ctrl_r[`LCR_CTRL_FORCE_BOOST]);
            red_pwm_r <= red_w;
            green_pwm_r <= green_w;
            blue_pwm_r <= blue_w;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    assign addr_phase = hsel & hready & (htrans == `LCR_HTRANS_NONSEQ ||
        htrans == `LCR_HTRANS_SEQ);

    always @*
    begin
        rd_mux = 32'h0000_0000;
        if (is_reg(haddr[`LCR_ADDR_W-1:0], `LCR_OFS_CMD))
            rd_mux = {16'h0000, cmd_r};
        else if (is_reg(haddr[`LCR_ADDR_W-1:0], `LCR_OFS_SHIFT))
            rd_mux = {16'h0000, shift_r};
        else if (is_reg(haddr[`LCR_ADDR_W-1:0], `LCR_OFS_STATUS))
            rd_mux = {17'h0_0000, bit_cnt_r, sink_drop_eff, pump_enable_r, boost_mode_r,
                ld_s[1], 1'b0};
        else if (is_reg(haddr[`LCR_ADDR_W-1:0], `LCR_OFS_CTRL))
            rd_mux = {30'h0000_0000, ctrl_r};
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= {`LCR_ADDR_W{1'b0}};
            ctrl_r <= `LCR_CTRL_RESET;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            // Read data registered in the address phase so it stands in the data phase
            if (addr_phase && !hwrite)
                hrdata <= rd_mux;
            dp_write_r <= addr_phase & hwrite;
            if (addr_phase)
                dp_addr_r <= haddr[`LCR_ADDR_W-1:0];
            if (dp_write_r && is_reg(dp_addr_r, `LCR_OFS_CTRL))
                ctrl_r <= hwdata[`LCR_CTRL_W-1:0];
        end
    end
endmodule // lcr_dimmer

// >>> hw/lcr_pwm_chan.v
// One colour channel duty-cycle comparator
`timescale 1ns/100ps
`include "lcr_consts.vh"

module lcr_pwm_chan #(
    parameter CNT_W = `LCR_PWM_CNT_W,
    parameter DUTY_W = `LCR_DUTY_W
) (
    input wire hclk,
    input wire hresetn,
    input wire enable,
    input wire [CNT_W-1:0] phase,
    input wire [DUTY_W-1:0] duty,
    output reg pwm_out_r
);
    wire [CNT_W-1:0] thresh;

    assign thresh = {duty, {(CNT_W-DUTY_W){1'b0}}};

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pwm_out_r <= 1'b0;
        else
            pwm_out_r <= enable & (phase < thresh);
    end
endmodule // lcr_pwm_chan

// >>> verification/lcr_dimmer_chk.sv
// Checker for the LED command port and dimmer outputs
`timescale 1ns/100ps
module lcr_dimmer_chk (
    input logic hclk,
    input logic hresetn,
    input logic load_strobe_n,
    input logic [5:0] sink_near_pump,
    input logic [6:0] main_level_pct_r,
    input logic [6:0] sub_level_pct_r,
    input logic [5:0] sink_current_en_r,
    input logic [5:0] sink_test_current_r,
    input logic pump_enable_r,
    input logic boost_mode_r,
    input logic red_pwm_r,
    input logic green_pwm_r,
    input logic blue_pwm_r
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_main_code: assert property (main_level_pct_r inside {7'h0, 7'h19, 7'h32, 7'h64})
        else $error("main level off its four values");
    a_sub_code: assert property (sub_level_pct_r inside {7'h0, 7'h19, 7'h32, 7'h64})
        else $error("sub level off its four values");
    a_cur_excl: assert property ((sink_current_en_r & sink_test_current_r) == 6'h0)
        else $error("sink has LED and test current together");
    // Near-pump must be steady past the synchroniser before the current is judged
    a_near_no_cur: assert property ((sink_current_en_r & $past(sink_near_pump, 2)
        & $past(sink_near_pump, 3) & $past(sink_near_pump, 4)) == 6'h0)
        else $error("LED current on a sink near the pump");
    a_boost_pump: assert property (boost_mode_r |-> pump_enable_r)
        else $error("boost without pump enable");
    a_strobe_hold: assert property (load_strobe_n [*6] |=> $stable(main_level_pct_r)
        && $stable(sub_level_pct_r))
        else $error("levels moved with strobe high");
    a_dark_no_pwm: assert property (!pump_enable_r [*4] |-> !(red_pwm_r || green_pwm_r
        || blue_pwm_r))
        else $error("colour output on with all codes zero");
    a_main_pump: assert property ((main_level_pct_r != 7'h0) [*2] |-> pump_enable_r)
        else $error("main display lit with pump idle");
endmodule // lcr_dimmer_chk

bind lcr_dimmer lcr_dimmer_chk lcr_dimmer_chk_i (.*);

// >>> verification/lcr_host_model.sv
// Host serial master model for the command port
`timescale 1ns/100ps
module lcr_host_model (
    output logic serial_data,
    output logic serial_clock,
    output logic load_strobe_n
);
    initial
    begin
        serial_data = 1'b0;
        serial_clock = 1'b1;
        load_strobe_n = 1'b1;
    end
    task automatic send(input logic [15:0] w, input logic load, input int half);
        // Keep pin changes off the system clock edges
        #3;
        for (int i = 15; i >= 0; i--)
        begin
            serial_clock = 1'b0;
            serial_data = w[i];
            #(half);
            serial_clock = 1'b1;
            #(half);
        end
        // Hold over, so the line must not look like a valid bit
        serial_data = ~w[0];
        if (load)
        begin
            load_strobe_n = 1'b0;
            #(2 * half);
            load_strobe_n = 1'b1;
        end
    endtask
endmodule // lcr_host_model

// >>> verification/tb.sv
// Self-checking bench for the LED command port and dimmer
`timescale 1ns/100ps
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic hwrite = 1'b0;
    logic pump_osc = 1'b0;
    logic secondary_led_sink_a = 1'b0;
    logic secondary_led_sink_b = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [3:0] primary_led_sinks = 4'h0;
    logic [5:0] sink_near_pump = 6'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic [6:0] main_level_pct_r, sub_level_pct_r;
    logic [5:0] sink_current_en_r, sink_test_current_r, on;
    logic [15:0] cmd;
    logic [11:0] m;
    logic hreadyout, hresp, serial_data, serial_clock, load_strobe_n;
    logic pump_enable_r, boost_mode_r, red_pwm_r, green_pwm_r, blue_pwm_r;
    integer failures = 0;
    integer checks = 0;
    integer seed = 32'hafabaa01;
    integer nr, ng, nb;
    lcr_dimmer lcr_dimmer_i (.*, .hready(hreadyout), .hsize(3'h2));
    lcr_host_model lcr_host_model_i (.*);
    always #10 hclk = ~hclk;
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        q = hrdata;
        chk(hresp, 0);
    endtask
    // Latch takes about four cycles after the strobe falls
    task automatic load(input logic [15:0] c);
        cmd = c;
        lcr_host_model_i.send(c, 1'b1, 80);
        repeat (8) @(posedge hclk);
    endtask
    initial
    begin
        repeat (20000) @(posedge hclk);
        failures++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({main_level_pct_r, sink_current_en_r, pump_enable_r, red_pwm_r}, 0);
        ahb(0, 8'h00, 0);
        chk(q, 0);
        ahb(0, 8'h0c, 0);
        chk(q, 1);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            m = $random(seed);
            {secondary_led_sink_b, secondary_led_sink_a, primary_led_sinks} <= m[5:0];
            sink_near_pump <= m[11:6];
            load({i[1:0], ~i[1:0], 12'($random(seed))});
            on = {{2{cmd[13:12] != 0}}, {4{cmd[15:14] != 0}}};
            chk(main_level_pct_r, cmd[15:14] == 3 ? 100 : cmd[15:14] * 25);
            chk(sub_level_pct_r, cmd[13:12] == 3 ? 100 : cmd[13:12] * 25);
            chk({sink_current_en_r, sink_test_current_r}, {on & ~m[11:6], on & m[11:6]});
            chk(boost_mode_r, cmd != 0 && (on & m[5:0] & ~m[11:6]) != 0);
            ahb(0, 8'h00, 0);
            chk(q, cmd);
        end
        $display("test levels done");
        {secondary_led_sink_b, secondary_led_sink_a, primary_led_sinks} <= 6'h3f;
        load(16'h0abc);
        chk({pump_enable_r, boost_mode_r}, 2'b10);
        lcr_host_model_i.send(16'hc123, 1'b0, 80);
        repeat (8) @(posedge hclk);
        ahb(1, 8'h00, 32'hffff);
        ahb(0, 8'h00, 0);
        chk(q, 32'h0abc);
        ahb(0, 8'h04, 0);
        chk(q, 32'hc123);
        ahb(0, 8'h08, 0);
        chk(q, 32'h400a);
        ahb(0, 8'h40, 0);
        chk(q, 0);
        ahb(1, 8'h0c, 32'h3);
        ahb(0, 8'h0c, 0);
        chk(q, 3);
        repeat (4) @(posedge hclk);
        chk(boost_mode_r, 1);
        ahb(1, 8'h0c, 32'h1);
        $display("test hold and bus done");
        for (int j = 0; j < 3; j++)
        begin
            load(j == 0 ? 16'h00f0 : 16'($random(seed)) & 16'h0fff);
            nr = 0;
            ng = 0;
            nb = 0;
            // One sample per oscillator period covers each phase once
            repeat (240)
            begin
                pump_osc <= 1'b1;
                repeat (4) @(posedge hclk);
                pump_osc <= 1'b0;
                repeat (4) @(posedge hclk);
                nr += red_pwm_r;
                ng += green_pwm_r;
                nb += blue_pwm_r;
            end
            chk(nr, cmd[3:0] * 16);
            chk(ng, cmd[7:4] * 16);
            chk(nb, cmd[11:8] * 16);
        end
        $display("test pwm done");
        print_verdict();
    end
endmodule // tb
